// file: bpf_pkg.sv
package bpf_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;

  // Control field positions and reset value.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_BURST_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Status field positions.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_WAIT_BIT = 5;
  localparam int STAT_CNT_LSB = 8;

  // Counter and address width.
  localparam int ADDR_W = 8;

  // Clock period and the memory page wait delay.
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned PAGE_WAIT_NS = 21;
  localparam int unsigned PAGE_WAIT_CYC =
    (PAGE_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Default half period of the processor clock, in clock cycles.
  localparam int unsigned CPU_HALF_DEF = 4;

  // Fetch sequencer states.
  typedef enum logic [4:0] {
    BPF_IDLE = 5'h01,
    BPF_FIRST = 5'h02,
    BPF_PAGE = 5'h04,
    BPF_BURST = 5'h08,
    BPF_SUSP = 5'h10
  } bpf_state_t;

  // Processor fetch request group.
  typedef struct packed {
    logic instr_request_n;
    logic burst_request_n;
    logic kill;
    logic [ADDR_W-1:0] addr;
  } bpf_cpu_req_t;

  // Memory control group.
  typedef struct packed {
    logic ale;
    logic ce_n;
    logic [ADDR_W-1:0] prom_addr_out;
  } bpf_prom_t;

  // APB request group.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } bpf_apb_req_t;

  // APB answer group.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bpf_apb_rsp_t;

endpackage

// file: bpf_top.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module bpf_top #(
  parameter int unsigned CPU_HALF_CYC = bpf_pkg::CPU_HALF_DEF
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register bus.
  input wire bpf_pkg::bpf_apb_req_t apb_i,
  output bpf_pkg::bpf_apb_rsp_t apb_o,
  // Processor side.
  input wire bpf_pkg::bpf_cpu_req_t cpu_i,
  output logic instr_ready_n_o,
  output logic processor_clock_out_o,
  // Memory side.
  input wire logic prom_wait_n_i,
  output bpf_pkg::bpf_prom_t prom_o
);

  bpf_pkg::bpf_state_t state_q;
  bpf_pkg::bpf_state_t state_d;
  logic [7:0] div_q;
  logic processor_clock_q;
  logic instr_ready_n_q;
  logic instr_ready_n_d;
  logic ale_q;
  logic ce_n_q;
  logic [bpf_pkg::ADDR_W-1:0] prom_addr_q;
  logic [bpf_pkg::ADDR_W-1:0] counter_bits_q;
  logic request_sync_q;
  logic burst_request_sync_q;
  logic kill_sync_q;
  logic extra_wait_flag_q;
  logic wait_prev_q;
  logic [3:0] win_q;
  logic [1:0] ctrl_q;
  logic [15:0] words_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Processor clock edge events, one clock cycle wide.
  wire half_end = (div_q == 8'(CPU_HALF_CYC - 1));
  wire rise_ev = half_end & ~processor_clock_q;
  wire fall_ev = half_end & processor_clock_q;

  // Control register fields.
  wire ctrl_en = ctrl_q[bpf_pkg::CTRL_EN_BIT];
  wire ctrl_burst_en = ctrl_q[bpf_pkg::CTRL_BURST_EN_BIT];

  // A new fetch is seen when the request is low at mid cycle.
  wire start = ctrl_en & ~cpu_i.instr_request_n;
  wire burst_go = ctrl_burst_en & ~burst_request_sync_q;
  wire win_done = (win_q >= 4'(bpf_pkg::PAGE_WAIT_CYC));
  wire wait_fell = wait_prev_q & ~prom_wait_n_i;
  wire wait_seen = extra_wait_flag_q | ~prom_wait_n_i;

  // Load pending marks the cycle in which the counter takes a new address.
  wire load_pending = fall_ev & start;
  // The wait clear term ends the extra wait once it has been served.
  wire wait_clear_term = fall_ev & (state_q == bpf_pkg::BPF_PAGE);

  // Burst states keep the latch enable under counter control.
  wire nxt_bursting = (state_d == bpf_pkg::BPF_BURST) |
                      (state_d == bpf_pkg::BPF_SUSP);
  wire in_burst = (state_q == bpf_pkg::BPF_BURST);
  wire paused = (state_q == bpf_pkg::BPF_SUSP);
  wire held_open = ~in_burst & ~paused;

  wire counter_clock = fall_ev & ale_q & nxt_bursting &
                       (state_q != bpf_pkg::BPF_IDLE) & ~start;

  wire sel_cpu = ~cpu_i.instr_request_n & ~cpu_i.kill & ale_q;
  wire [bpf_pkg::ADDR_W-1:0] prom_addr_d = sel_cpu ? cpu_i.addr
                                                   : counter_bits_q;

  wire ce_n_d = cpu_i.instr_request_n & burst_request_sync_q;

  // APB decode.
  wire apb_access = apb_i.psel & apb_i.penable;
  wire apb_answer = apb_access & ~pready_q;
  wire hit_ctrl = (apb_i.paddr == bpf_pkg::OFF_CTRL);
  wire hit_status = (apb_i.paddr == bpf_pkg::OFF_STATUS);
  wire hit_count = (apb_i.paddr == bpf_pkg::OFF_COUNT);
  wire apb_hit = hit_ctrl | hit_status | hit_count;
  wire ctrl_wr = apb_access & pready_q & apb_i.pwrite & hit_ctrl;

  // Status word shows the sequencer state, wait flag and counter.
  wire [31:0] status_word = {16'h0000, counter_bits_q, 2'h0,
                             extra_wait_flag_q, state_q};
  wire [31:0] rd_word = hit_ctrl ? {30'h00000000, ctrl_q} :
                        hit_status ? status_word :
                        hit_count ? {16'h0000, words_q} : 32'h00000000;

  // Sequencer next state and ready, applied at mid cycle only.
  always_comb
  begin
    state_d = state_q;
    instr_ready_n_d = instr_ready_n_q;
    unique case (state_q)
      bpf_pkg::BPF_IDLE:
      begin
        instr_ready_n_d = 1'b1;
        if (start)
        begin
          state_d = bpf_pkg::BPF_FIRST;
        end
      end
      bpf_pkg::BPF_FIRST:
      begin
        if (cpu_i.kill)
        begin
          state_d = bpf_pkg::BPF_IDLE;
          instr_ready_n_d = 1'b1;
        end
        else if (!win_done)
        begin
          instr_ready_n_d = 1'b1;
        end
        else if (wait_seen)
        begin
          state_d = bpf_pkg::BPF_PAGE;
          instr_ready_n_d = 1'b1;
        end
        else
        begin
          instr_ready_n_d = 1'b0;
          state_d = burst_go ? bpf_pkg::BPF_BURST : bpf_pkg::BPF_IDLE;
        end
      end
      bpf_pkg::BPF_PAGE:
      begin
        instr_ready_n_d = 1'b0;
        state_d = burst_go ? bpf_pkg::BPF_BURST : bpf_pkg::BPF_IDLE;
      end
      bpf_pkg::BPF_BURST:
      begin
        if (start)
        begin
          state_d = bpf_pkg::BPF_FIRST;
          instr_ready_n_d = 1'b1;
        end
        else if (cpu_i.kill || !ctrl_burst_en)
        begin
          state_d = bpf_pkg::BPF_IDLE;
          instr_ready_n_d = 1'b1;
        end
        else if (!burst_request_sync_q)
        begin
          instr_ready_n_d = 1'b0;
        end
        else
        begin
          state_d = bpf_pkg::BPF_SUSP;
          instr_ready_n_d = 1'b1;
        end
      end
      bpf_pkg::BPF_SUSP:
      begin
        instr_ready_n_d = 1'b1;
        if (start)
        begin
          state_d = bpf_pkg::BPF_FIRST;
        end
        else if (cpu_i.kill || !ctrl_burst_en)
        begin
          state_d = bpf_pkg::BPF_IDLE;
        end
        else if (!burst_request_sync_q)
        begin
          state_d = bpf_pkg::BPF_BURST;
          instr_ready_n_d = 1'b0;
        end
      end
      default:
      begin
        state_d = bpf_pkg::BPF_IDLE;
        instr_ready_n_d = 1'b1;
      end
    endcase
  end

  // Processor clock divider.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q <= 8'h00;
      processor_clock_q <= 1'b0;
    end
    else
    begin
      div_q <= half_end ? 8'h00 : div_q + 8'h01;
      processor_clock_q <= processor_clock_q ^ half_end;
    end
  end

  // Sequencer state and ready, updated at mid cycle.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= bpf_pkg::BPF_IDLE;
      instr_ready_n_q <= 1'b1;
    end
    else if (fall_ev)
    begin
      state_q <= state_d;
      instr_ready_n_q <= instr_ready_n_d;
    end
  end

  // Request samples: request and kill at mid cycle, burst at rising edge.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      request_sync_q <= 1'b1;
      kill_sync_q <= 1'b0;
      burst_request_sync_q <= 1'b1;
    end
    else
    begin
      if (fall_ev)
      begin
        request_sync_q <= cpu_i.instr_request_n;
        kill_sync_q <= cpu_i.kill;
      end
      if (rise_ev)
      begin
        burst_request_sync_q <= cpu_i.burst_request_n;
      end
    end
  end

  // Latch enable, moved on the same edges as the processor clock.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ale_q <= 1'b1;
    end
    else if (fall_ev)
    begin
      ale_q <= ~nxt_bursting | start;
    end
    else if (rise_ev)
    begin
      // open from burst request, also on resume so the held address loads
      ale_q <= held_open | ((in_burst | paused) & ~cpu_i.burst_request_n &
                            ~extra_wait_flag_q);
    end
  end

  // Burst counter: load on a new fetch, step on each latch fall.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      counter_bits_q <= '0;
    end
    else if (load_pending)
    begin
      counter_bits_q <= cpu_i.addr;
    end
    else if (counter_clock)
    begin
      counter_bits_q <= counter_bits_q + 8'h01;
    end
  end

  // Page wait window and extra wait flag; a set wins over a clear.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wait_prev_q <= 1'b1;
      win_q <= 4'h0;
      extra_wait_flag_q <= 1'b0;
    end
    else
    begin
      wait_prev_q <= prom_wait_n_i;
      if (load_pending)
      begin
        win_q <= 4'h0;
      end
      else if (!win_done)
      begin
        win_q <= win_q + 4'h1;
      end
      if (wait_fell && state_q == bpf_pkg::BPF_FIRST)
      begin
        extra_wait_flag_q <= 1'b1;
      end
      else if (wait_clear_term || load_pending)
      begin
        extra_wait_flag_q <= 1'b0;
      end
    end
  end

  // Memory address and chip enable registers.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prom_addr_q <= '0;
      ce_n_q <= 1'b1;
    end
    else
    begin
      prom_addr_q <= prom_addr_d;
      ce_n_q <= ce_n_d;
    end
  end

  // Delivered word count, one per ready seen at a processor rising edge.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      words_q <= 16'h0000;
    end
    else if (rise_ev && !instr_ready_n_q)
    begin
      words_q <= words_q + 16'h0001;
    end
  end

  // Control register write, taken when the access completes.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= bpf_pkg::CTRL_RESET;
    end
    else if (ctrl_wr)
    begin
      ctrl_q <= apb_i.pwdata[1:0];
    end
  end

  // APB answer: one wait cycle, then ready with data and error.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= apb_answer;
      pslverr_q <= apb_answer & ~apb_hit;
      if (apb_answer && !apb_i.pwrite)
      begin
        prdata_q <= rd_word;
      end
    end
  end

  // Output wiring, every bit from a register.
  assign instr_ready_n_o = instr_ready_n_q;
  assign processor_clock_out_o = processor_clock_q;
  assign prom_o.ale = ale_q;
  assign prom_o.ce_n = ce_n_q;
  assign prom_o.prom_addr_out = prom_addr_q;
  assign apb_o.prdata = prdata_q;
  assign apb_o.pready = pready_q;
  assign apb_o.pslverr = pslverr_q;

endmodule

// file: bpf_chk.sv
`timescale 1ns/10ps
// Watches the fetch interface and register bus ports for timing faults.
module bpf_chk #(
  parameter int unsigned CPU_HALF_CYC = 4
) (
  // Clock, reset and register bus.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire bpf_pkg::bpf_apb_req_t apb_i,
  input wire bpf_pkg::bpf_apb_rsp_t apb_o,
  // Processor and memory sides.
  input wire bpf_pkg::bpf_cpu_req_t cpu_i,
  input wire logic instr_ready_n_o,
  input wire logic processor_clock_out_o,
  input wire logic prom_wait_n_i,
  input wire bpf_pkg::bpf_prom_t prom_o
);
  logic pc_q;
  logic seen_q;
  int unsigned hc_q;
  int unsigned kc_q;
  int unsigned ic_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Counts cycles since a clock toggle, of kill, and of idle requests.
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      pc_q <= 1'b0;
      seen_q <= 1'b0;
      hc_q <= 0;
      kc_q <= 0;
      ic_q <= 0;
    end
    else
    begin
      pc_q <= processor_clock_out_o;
      seen_q <= seen_q | (pc_q != processor_clock_out_o);
      hc_q <= (pc_q != processor_clock_out_o) ? 0 : hc_q + 1;
      kc_q <= cpu_i.kill ? kc_q + 1 : 0;
      ic_q <= (cpu_i.instr_request_n & cpu_i.burst_request_n) ? ic_q + 1 : 0;
    end
  a_half_period:
    assert property (seen_q && pc_q != processor_clock_out_o |-> hc_q == CPU_HALF_CYC - 1)
    else $error("processor clock half period wrong");
  a_ready_mid:
    assert property ($changed(instr_ready_n_o) |-> !processor_clock_out_o)
    else $error("ready changed outside clock low phase");
  a_ale_fall_mid:
    assert property ($fell(prom_o.ale) |-> !processor_clock_out_o)
    else $error("latch enable fell outside clock low phase");
  a_addr_load:
    assert property (!cpu_i.instr_request_n && !cpu_i.kill && prom_o.ale
      |=> prom_o.prom_addr_out == $past(cpu_i.addr))
    else $error("memory address does not follow processor address");
  a_ce_request:
    assert property (!cpu_i.instr_request_n |=> !prom_o.ce_n)
    else $error("chip enable not asserted for request");
  a_ce_idle:
    assert property (ic_q > 2 * CPU_HALF_CYC + 1 |-> prom_o.ce_n)
    else $error("chip enable asserted while idle");
  a_kill_ready:
    assert property (kc_q > 2 * CPU_HALF_CYC |-> instr_ready_n_o)
    else $error("ready asserted during kill");
  a_first_wait:
    assert property ($fell(cpu_i.instr_request_n) && !cpu_i.kill && instr_ready_n_o
      |-> instr_ready_n_o [*6] ##[1:30] !instr_ready_n_o)
    else $error("first access wait wrong");
  a_pready_pulse:
    assert property (apb_o.pready |-> apb_i.psel && apb_i.penable ##1 !apb_o.pready)
    else $error("pready outside access or too long");
  a_err_pready:
    assert property (apb_o.pslverr |-> apb_o.pready)
    else $error("pslverr without pready");
endmodule
bind bpf_top bpf_chk #(.CPU_HALF_CYC(CPU_HALF_CYC)) CHK (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .apb_i(apb_i), .apb_o(apb_o), .cpu_i(cpu_i), .instr_ready_n_o(instr_ready_n_o),
  .processor_clock_out_o(processor_clock_out_o), .prom_wait_n_i(prom_wait_n_i),
  .prom_o(prom_o));

// file: bpf_prom_model.sv
`timescale 1ns/10ps
// Paged memory: address latch and page wait output.
module bpf_prom_model #(
  parameter int unsigned HOLD = 12,
  parameter int unsigned DLY = 3
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Interface side.
  input wire bpf_pkg::bpf_prom_t prom_i,
  input wire logic [3:0] page_i,
  output logic wait_n_o,
  output logic [7:0] lat_o
);
  logic [3:0] pg_q;
  int unsigned wc_q;
  int unsigned dc_q;
  // page wait held while the count runs.
  assign wait_n_o = (wc_q == 0);
  // latch follows while enable is high.
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      pg_q <= 4'h0;
      wc_q <= 0;
      dc_q <= 0;
      lat_o <= 8'h00;
    end
    else
    begin
      if (prom_i.ale)
        lat_o <= prom_i.prom_addr_out;
      // The page wait falls a few cycles after the change, well inside its limit.
      if (page_i != pg_q && !prom_i.ce_n)
      begin
        pg_q <= page_i;
        dc_q <= DLY + 1;
      end
      else if (dc_q != 0)
        dc_q <= dc_q - 1;
      if (dc_q == 1)
        wc_q <= HOLD;
      else if (wc_q != 0)
        wc_q <= wc_q - 1;
    end
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  bpf_pkg::bpf_apb_req_t apb_i = '0;
  bpf_pkg::bpf_apb_rsp_t apb_o;
  bpf_pkg::bpf_cpu_req_t cpu_i = '{1'b1, 1'b1, 1'b0, 8'h00};
  bpf_pkg::bpf_prom_t prom_o;
  logic rdy_n;
  logic pclk;
  logic wait_n;
  logic [3:0] page = 4'h0;
  logic [7:0] lat;
  logic [15:0] rnd = 16'h9687;
  logic [33:0] ae;
  logic [7:0] wq[$];
  logic [33:0] aq[$];
  int fail_count = 0;
  int n_tests = 0;
  int total = 0;
  always #2 mclk_i = ~mclk_i;
  bpf_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o),
    .cpu_i(cpu_i), .instr_ready_n_o(rdy_n), .processor_clock_out_o(pclk),
    .prom_wait_n_i(wait_n), .prom_o(prom_o));
  bpf_prom_model PROM (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .prom_i(prom_o),
    .page_i(page), .wait_n_o(wait_n), .lat_o(lat));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One register transfer; e holds check flag, error and data.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [33:0] e);
    @(posedge mclk_i);
    aq.push_back(e);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk_i);
    apb_i.penable <= 1'b1;
    do
    begin
      @(posedge mclk_i);
    end
    while (apb_o.pready !== 1'b1);
    apb_i <= '0;
  endtask
  // fetch of n words, suspended after word sk, ew waits expected.
  task automatic fetch(input logic [7:0] a, input int n, input int sk,
    input logic [3:0] pg, input int ew);
    int w;
    int d;
    for (int i = 0; i < n; i++)
      wq.push_back(a + 8'(i));
    total += n;
    @(posedge pclk);
    cpu_i <= '{1'b0, n < 2, 1'b0, a};
    page <= pg;
    @(posedge pclk);
    cpu_i.instr_request_n <= 1'b1;
    w = 0;
    d = 0;
    while (d < n)
    begin
      if (rdy_n === 1'b0)
        d++;
      else if (d == 0)
        w++;
      if (d == n - 1 || d == sk - 1)
        cpu_i.burst_request_n <= 1'b1;
      if (d == sk && rdy_n !== 1'b0)
        cpu_i.burst_request_n <= 1'b0;
      if (d < n)
        @(posedge pclk);
    end
    check("wait cycles", ew, w);
  endtask
  // Each delivered word is compared with the oldest expected address.
  always @(posedge pclk)
  begin
    #1;
    if (rdy_n === 1'b0)
      check("word address", {24'h0, wq.pop_front()}, {24'h0, lat});
  end
  // Each register answer is compared with the oldest note.
  always @(posedge mclk_i)
    if (apb_o.pready === 1'b1)
    begin
      ae = aq.pop_front();
      check("pslverr", {31'h0, ae[32]}, {31'h0, apb_o.pslverr});
      if (ae[33])
        check("prdata", ae[31:0], apb_o.prdata);
    end
  // Cuts a hang short.
  initial
  begin
    #40000;
    fail_count++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, bpf_pkg::OFF_CTRL, 32'h0, {2'b10, 32'h3});
    apb(1'b1, bpf_pkg::OFF_CTRL, 32'h0, 34'h0);
    apb(1'b0, bpf_pkg::OFF_CTRL, 32'h0, {2'b10, 32'h0});
    apb(1'b1, bpf_pkg::OFF_CTRL, 32'h3, 34'h0);
    apb(1'b1, 8'h0c, 32'h1, {2'b01, 32'h0});
    apb(1'b0, 8'h0c, 32'h0, {2'b11, 32'h0});
    $display("done: registers");
    fetch(8'h10, 1, -1, 4'h0, 1);
    fetch(8'h20, 4, -1, 4'h1, 2);
    fetch(8'hfd, 6, 3, 4'h1, 1);
    $display("done: bursts");
    @(posedge pclk);
    cpu_i <= '{1'b0, 1'b1, 1'b1, 8'h55};
    @(posedge pclk);
    cpu_i.instr_request_n <= 1'b1;
    repeat (2) @(posedge pclk);
    cpu_i.kill <= 1'b0;
    fetch(8'h40, 2, -1, 4'h1, 1);
    for (int i = 0; i < 5; i++)
    begin
      rnd = lfsr(rnd);
      fetch(rnd[7:0], 1 + int'(rnd[10:8]), -1, rnd[15:12], (rnd[15:12] != page) ? 2 : 1);
    end
    $display("done: kill and random");
    apb(1'b1, bpf_pkg::OFF_COUNT, 32'hffff, 34'h0);
    apb(1'b0, bpf_pkg::OFF_COUNT, 32'h0, {2'b10, 32'(total)});
    $display("done: count");
    repeat (4) @(posedge pclk);
    test_done();
  end
endmodule
